//--- design/adc_serial_config_interface.sv
// Serial interface and configuration register of a SAR converter
`timescale 1ns/1ns
`default_nettype none
`include "asci_map.svh"

module adc_serial_config_interface (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_convert_strobe,
    input wire logic i_sdi,
    input wire logic i_busy_select,
    input wire logic i_overvoltage,
    input wire logic [15:0] i_sample_code,
    output logic o_sdo,
    output logic o_sdo_oe_n,
    output logic o_converting,
    output logic o_acquiring,
    output logic o_span_compress,
    output logic o_high_z,
    output logic o_turbo,
    output logic o_status_en
);

    // ****************************************************************
    // Core domain: synchronised pins
    // ****************************************************************
    logic cnv_s;
    logic sdi_s;
    logic busy_sel_s;
    logic ov_s;
    logic wr_tgl_s;
    logic rd_tgl_s;
    logic wr_tgl;
    logic rd_tgl;

    asci_sync #(.W(6)) u_sync (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_d({i_convert_strobe, i_sdi, i_busy_select, i_overvoltage, wr_tgl, rd_tgl}),
        .o_q({cnv_s, sdi_s, busy_sel_s, ov_s, wr_tgl_s, rd_tgl_s})
    );

    logic cnv_d;
    logic wr_tgl_d;
    logic rd_tgl_d;
    logic cnv_rise;
    logic cnv_fall;
    logic wr_evt;
    logic rd_evt;

    // Edge history of synchronised levels and toggles
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cnv_d <= 1'b0;
            wr_tgl_d <= 1'b0;
            rd_tgl_d <= 1'b0;
        end
        else
        begin
            cnv_d <= cnv_s;
            wr_tgl_d <= wr_tgl_s;
            rd_tgl_d <= rd_tgl_s;
        end
    end

    assign cnv_rise = cnv_s & ~cnv_d;
    assign cnv_fall = ~cnv_s & cnv_d;
    assign wr_evt = wr_tgl_s ^ wr_tgl_d;
    assign rd_evt = rd_tgl_s ^ rd_tgl_d;

    // ****************************************************************
    // Core domain: conversion timing
    // ****************************************************************
    logic conv_busy;
    logic conv_acq;
    logic conv_done;

    asci_conv_timer u_timer (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_start(cnv_rise),
        .o_converting(conv_busy),
        .o_acquiring(conv_acq),
        .o_done(conv_done)
    );

    // ****************************************************************
    // Core domain: configuration register
    // ****************************************************************
    asci_pkg::asci_cfg_s cfg;
    logic ov_event;
    logic [7:0] wr_data;

    // Writable enables; reserved bits and flag never take write data
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            cfg.reserved <= 3'h0;
            cfg.status_en <= 1'b0;
            cfg.span_compress <= 1'b0;
            cfg.high_z <= 1'b0;
            cfg.turbo <= 1'b0;
        end
        else if (wr_evt)
        begin
            cfg.reserved <= 3'h0;
            cfg.status_en <= wr_data[`ASCI_CFG_STATUS_EN_BIT];
            cfg.span_compress <= wr_data[`ASCI_CFG_SPAN_BIT];
            cfg.high_z <= wr_data[`ASCI_CFG_HIGHZ_BIT];
            cfg.turbo <= wr_data[`ASCI_CFG_TURBO_BIT];
        end
    end

    // Sticky overvoltage memory; a new event beats the clear-on-read
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ov_event <= 1'b0;
        end
        else if (ov_s)
        begin
            ov_event <= 1'b1;
        end
        else if (rd_evt)
        begin
            ov_event <= 1'b0;
        end
    end

    assign cfg.ov_ok = ~ov_event;

    // ****************************************************************
    // Core domain: result word for the link
    // ****************************************************************
    asci_pkg::asci_tx_s tx_word;
    logic [15:0] pending;
    logic pending_vld;
    logic busy_on;
    logic powerup;

    assign busy_on = busy_sel_s & ~cfg.turbo;

    // A result must not change under a running readback, so it is
    // published at once only when no frame can be clocking it out;
    // otherwise it waits for the next conversion start.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            tx_word <= '0;
            pending <= 16'h0000;
            pending_vld <= 1'b0;
        end
        else
        begin
            if (conv_done && (cnv_s || busy_on))
            begin
                tx_word.result <= i_sample_code;
                pending_vld <= 1'b0;
            end
            else if (conv_done)
            begin
                pending <= i_sample_code;
                pending_vld <= 1'b1;
            end
            else if (cnv_rise && pending_vld)
            begin
                tx_word.result <= pending;
                pending_vld <= 1'b0;
            end
            tx_word.status <= {cfg.ov_ok, cfg.span_compress, cfg.high_z, cfg.turbo, 2'b00};
        end
    end

    // Power-up state lasts until the first frame opens
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            powerup <= 1'b1;
        end
        else if (cnv_fall)
        begin
            powerup <= 1'b0;
        end
    end

    // ****************************************************************
    // Core domain: pin enable and feature outputs
    // ****************************************************************
    // With busy selected and turbo off, busy is shown by holding SDO released until the result is ready;
    // the line then drops low, which the host can use as a ready edge.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_sdo_oe_n <= 1'b0;
        end
        else if (powerup)
        begin
            o_sdo_oe_n <= cnv_s & sdi_s;
        end
        else if (cnv_s)
        begin
            o_sdo_oe_n <= 1'b1;
        end
        else if (busy_on)
        begin
            o_sdo_oe_n <= conv_busy | pending_vld;
        end
        else
        begin
            o_sdo_oe_n <= 1'b0;
        end
    end

    // Feature enables towards the analog front end
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_span_compress <= 1'b0;
            o_high_z <= 1'b0;
            o_turbo <= 1'b0;
            o_status_en <= 1'b0;
            o_converting <= 1'b0;
            o_acquiring <= 1'b1;
        end
        else
        begin
            o_span_compress <= cfg.span_compress;
            o_high_z <= cfg.high_z;
            o_turbo <= cfg.turbo;
            o_status_en <= cfg.status_en;
            o_converting <= conv_busy;
            o_acquiring <= conv_acq;
        end
    end

    // ****************************************************************
    // Link domain: frame on SCK, cleared while the strobe is high
    // ****************************************************************
    // The strobe ends the frame asynchronously because SCK stops
    // between frames; words read from the core are held stable by it.
    logic frame_rst;
    logic [4:0] rise_cnt;
    logic [4:0] fall_cnt;
    logic [6:0] rx_sr;
    logic cmd_ok;
    logic cmd_read;
    logic sdi_q;
    logic [7:0] rx_byte;

    assign frame_rst = i_rst | i_convert_strobe;

    // Rising edges: capture SDI and decode the command byte
    always_ff @(posedge i_sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            rise_cnt <= 5'h00;
            rx_sr <= 7'h00;
            cmd_ok <= 1'b0;
            cmd_read <= 1'b0;
            sdi_q <= 1'b0;
        end
        else
        begin
            sdi_q <= i_sdi;
            rx_sr <= {rx_sr[5:0], i_sdi};
            if (rise_cnt != 5'h1F)
            begin
                rise_cnt <= rise_cnt + 5'h01;
            end
            if (rise_cnt == 5'(`ASCI_CMD_BITS - 1))
            begin
                cmd_ok <= !rx_sr[6] && ({rx_sr[4:0], i_sdi} == `ASCI_CMD_PATTERN);
                cmd_read <= rx_sr[5];
            end
        end
    end

    // Data byte and event toggles survive the frame reset on purpose
    always_ff @(posedge i_sck or posedge i_rst)
    begin
        if (i_rst)
        begin
            rx_byte <= 8'h00;
            wr_tgl <= 1'b0;
            rd_tgl <= 1'b0;
        end
        else if (!i_convert_strobe)
        begin
            if (rise_cnt == 5'(`ASCI_INSTR_BITS - 1) && cmd_ok && !cmd_read)
            begin
                rx_byte <= {rx_sr, i_sdi};
                wr_tgl <= ~wr_tgl;
            end
            // Clear request only after bit 0 has left, so this read still shows the event
            if (rise_cnt == 5'(`ASCI_INSTR_BITS - 1) && cmd_ok && cmd_read)
            begin
                rd_tgl <= ~rd_tgl;
            end
        end
    end

    assign wr_data = rx_byte & `ASCI_CFG_WRITE_MASK;

    // Falling edges: shift result, status, register or chained data
    always_ff @(negedge i_sck or posedge frame_rst)
    begin
        if (frame_rst)
        begin
            fall_cnt <= 5'h00;
            o_sdo <= 1'b0;
        end
        else
        begin
            if (fall_cnt != 5'h1F)
            begin
                fall_cnt <= fall_cnt + 5'h01;
            end
            if (cmd_ok && cmd_read && fall_cnt >= 5'(`ASCI_CMD_BITS - 1) &&
                fall_cnt < 5'(`ASCI_INSTR_BITS - 1))
            begin
                o_sdo <= cfg[3'(5'(`ASCI_INSTR_BITS - 2) - fall_cnt)];
            end
            else if (fall_cnt < 5'(`ASCI_RESULT_BITS))
            begin
                o_sdo <= tx_word.result[4'(5'(`ASCI_RESULT_BITS - 1) - fall_cnt)];
            end
            else if (cfg.status_en && fall_cnt < 5'(`ASCI_FRAME_OWN_BITS))
            begin
                o_sdo <= tx_word.status[3'(5'(`ASCI_FRAME_OWN_BITS - 1) - fall_cnt)];
            end
            else
            begin
                o_sdo <= sdi_q;
            end
        end
    end

endmodule : adc_serial_config_interface

`default_nettype wire

//--- design/asci_map.svh
// Constants of the converter serial configuration interface
`ifndef ASCI_MAP_SVH
`define ASCI_MAP_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define ASCI_CLK_MHZ 25
`define ASCI_DIGITIZE_TIME_NS 290
`define ASCI_EARLY_ACQ_NS 100
// Longest times round down to whole cycles
`define ASCI_DIGITIZE_CYC ((`ASCI_DIGITIZE_TIME_NS * `ASCI_CLK_MHZ) / 1000)
`define ASCI_ACQ_START_CYC (((`ASCI_DIGITIZE_TIME_NS - `ASCI_EARLY_ACQ_NS) * `ASCI_CLK_MHZ) / 1000)

// ****************************************************************
// Configuration register fields and reset values
// ****************************************************************
`define ASCI_CFG_STATUS_EN_BIT 4
`define ASCI_CFG_SPAN_BIT 3
`define ASCI_CFG_HIGHZ_BIT 2
`define ASCI_CFG_TURBO_BIT 1
`define ASCI_CFG_OV_BIT 0
`define ASCI_CFG_WRITE_MASK 8'h1E
`define ASCI_CFG_RESET 8'h01

// ****************************************************************
// Serial frame layout
// ****************************************************************
`define ASCI_CMD_PATTERN 6'h14
`define ASCI_CMD_BITS 8
`define ASCI_INSTR_BITS 16
`define ASCI_RESULT_BITS 16
`define ASCI_STATUS_BITS 6
`define ASCI_FRAME_OWN_BITS 22

`endif

//--- design/asci_pkg.sv
// Types shared by the converter serial configuration interface
package asci_pkg;

    // Conversion sequencer phases
    typedef enum logic [1:0] {
        CONV_IDLE,
        CONV_QUIET,
        CONV_TAIL
    } asci_conv_e;

    // Configuration register layout, MSB first
    typedef struct packed {
        logic [2:0] reserved;
        logic status_en;
        logic span_compress;
        logic high_z;
        logic turbo;
        logic ov_ok;
    } asci_cfg_s;

    // Word handed to the link side: result and status
    typedef struct packed {
        logic [15:0] result;
        logic [5:0] status;
    } asci_tx_s;

endpackage : asci_pkg

//--- design/asci_sync.sv
// Two-flop level synchroniser, one stage pair per bit
`timescale 1ns/1ns
`default_nettype none

module asci_sync #(
    parameter int W = 1
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);

    logic [W-1:0] meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            meta <= '0;
            o_q <= '0;
        end
        else
        begin
            meta <= i_d;
            o_q <= meta;
        end
    end

endmodule : asci_sync

`default_nettype wire

//--- design/asci_conv_timer.sv
// Conversion phase timer: digitize window, early acquisition, power-down
`timescale 1ns/1ns
`default_nettype none
`include "asci_map.svh"

module asci_conv_timer (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_converting,
    output logic o_acquiring,
    output logic o_done
);

    localparam logic [3:0] LAST_CYC = 4'(`ASCI_DIGITIZE_CYC - 1);
    localparam logic [3:0] ACQ_CYC = 4'(`ASCI_ACQ_START_CYC);

    asci_pkg::asci_conv_e state;
    logic [3:0] cnt;

    // Phase sequencer; a start while busy is ignored
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= asci_pkg::CONV_IDLE;
            cnt <= 4'h0;
        end
        else
        begin
            unique case (state)
                asci_pkg::CONV_IDLE:
                begin
                    cnt <= 4'h0;
                    if (i_start)
                    begin
                        state <= asci_pkg::CONV_QUIET;
                    end
                end
                asci_pkg::CONV_QUIET:
                begin
                    cnt <= cnt + 4'h1;
                    if (cnt + 4'h1 == ACQ_CYC)
                    begin
                        state <= asci_pkg::CONV_TAIL;
                    end
                end
                asci_pkg::CONV_TAIL:
                begin
                    cnt <= cnt + 4'h1;
                    if (cnt == LAST_CYC)
                    begin
                        state <= asci_pkg::CONV_IDLE;
                    end
                end
            endcase
        end
    end

    // Outputs registered; conversion circuitry powered only while converting
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_converting <= 1'b0;
            o_acquiring <= 1'b1;
            o_done <= 1'b0;
        end
        else
        begin
            o_converting <= (state == asci_pkg::CONV_IDLE) ? i_start :
                            !(state == asci_pkg::CONV_TAIL && cnt == LAST_CYC);
            o_acquiring <= (state == asci_pkg::CONV_IDLE) ? !i_start :
                           (state == asci_pkg::CONV_TAIL || cnt + 4'h1 == ACQ_CYC);
            o_done <= (state == asci_pkg::CONV_TAIL && cnt == LAST_CYC);
        end
    end

endmodule : asci_conv_timer

`default_nettype wire

//--- bench/asci_host_model.sv
// Host side model: mode 0 serial master driving strobe, SCK and SDI
`timescale 1ns/1ns
`default_nettype none

module asci_host_model (
    input wire logic i_sdo,
    input wire logic i_sdo_oe_n,
    output var logic o_sck,
    output var logic o_strobe,
    output var logic o_sdi
);
    // Line as the host sees it: the inverse of SDO whenever the device lets go
    wire logic sdo_line = i_sdo_oe_n ? ~i_sdo : i_sdo;

    // Idle between frames: strobe and SDI high, SCK parked low
    initial
    begin
        o_sck = 1'b0;
        o_strobe = 1'b1;
        o_sdi = 1'b1;
    end

    // One frame, MSB first, 32 ns SCK that only runs inside the frame
    // 31.25 MHz covers 16 result plus 6 status bits at the slow frame rate used here
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h00000000;
        #7 o_strobe = 1'b0;
        #200;
        for (int i = n - 1; i >= 0; i--)
        begin
            o_sdi = tx[i];
            #16 o_sck = 1'b1;
            rx = {rx[30:0], sdo_line};
            #16 o_sck = 1'b0;
        end
        #16 o_strobe = 1'b1;
        #16 o_sdi = 1'b1;
    endtask : frame

    // Start a conversion, then reopen the frame while it still runs; strobe stays low
    task automatic early_open();
        #7 o_strobe = 1'b0;
        #100 o_strobe = 1'b1;
        #120 o_strobe = 1'b0;
    endtask : early_open
endmodule : asci_host_model
`default_nettype wire

//--- bench/asci_checker_asserts.sv
// Concurrent checks on the converter serial interface ports
`timescale 1ns/1ns
`default_nettype none

module asci_checker (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_convert_strobe,
    input wire logic i_sdi,
    input wire logic i_busy_select,
    input wire logic i_overvoltage,
    input wire logic [15:0] i_sample_code,
    input wire logic o_sdo,
    input wire logic o_sdo_oe_n,
    input wire logic o_converting,
    input wire logic o_acquiring,
    input wire logic o_span_compress,
    input wire logic o_high_z,
    input wire logic o_turbo,
    input wire logic o_status_en
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    logic [3:0] since_low;
    wire logic [3:0] cfg = {o_status_en, o_span_compress, o_high_z, o_turbo};

    // Cycles since the strobe was low; a write can only land just after a frame
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            since_low <= 4'hF;
        else if (!i_convert_strobe)
            since_low <= 4'h0;
        else if (since_low != 4'hF)
            since_low <= since_low + 4'h1;
    end

    // ****************************************************************
    // Assertions
    // ****************************************************************
    conv_len_a: assert property ($rose(o_converting) |-> o_converting [*7] ##1 !o_converting)
        else $error("conversion window not seven cycles");
    early_acq_a: assert property ($rose(o_converting) |-> !o_acquiring [*4] ##1 o_acquiring)
        else $error("acquisition did not restart early");
    power_down_a: assert property ($fell(o_converting) |-> o_acquiring && $past(o_acquiring, 3))
        else $error("conversion ended without early acquisition");
    idle_acq_a: assert property (!o_converting |-> o_acquiring)
        else $error("not acquiring while idle");
    strobe_hiz_a: assert property ((i_convert_strobe && i_sdi) [*5] |-> o_sdo_oe_n)
        else $error("SDO still driven with strobe and SDI high");
    sdo_quiet_a: assert property (i_convert_strobe |-> !o_sdo)
        else $error("SDO data not cleared while strobe high");
    rst_state_a: assert property ($fell(i_rst) |-> !o_sdo && !o_sdo_oe_n && o_acquiring && !o_converting)
        else $error("power-up pin state wrong");
    cfg_reset_a: assert property ($fell(i_rst) |-> cfg == 4'h0)
        else $error("config enables not cleared at reset");
    cfg_path_a: assert property (!$stable(cfg) |-> since_low <= 4'h8)
        else $error("config changed without a serial frame");

    cover property ($rose(o_converting));
    cover property ($rose(o_turbo));
    cover property ($fell(o_status_en));
    cover property (o_sdo_oe_n && o_converting && !i_convert_strobe);
endmodule : asci_checker

bind adc_serial_config_interface asci_checker u_asci_checker (
    .i_clk(i_clk), .i_rst(i_rst), .i_sck(i_sck), .i_convert_strobe(i_convert_strobe), .i_sdi(i_sdi),
    .i_busy_select(i_busy_select), .i_overvoltage(i_overvoltage), .i_sample_code(i_sample_code),
    .o_sdo(o_sdo), .o_sdo_oe_n(o_sdo_oe_n), .o_converting(o_converting), .o_acquiring(o_acquiring),
    .o_span_compress(o_span_compress), .o_high_z(o_high_z), .o_turbo(o_turbo), .o_status_en(o_status_en)
);
`default_nettype wire

//--- bench/adc_serial_config_interface_bench.sv
// Self-checking bench of the converter serial configuration interface
`timescale 1ns/1ns
`default_nettype none
`define CHK(name, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
    $display("unexpected %s: expected %h, seen %h", name, exp, got); end end

module adc_serial_config_interface_bench;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic busy_sel = 1'b0;
    logic ovr = 1'b0;
    logic [15:0] code = 16'h0000;
    wire logic sck, strobe, sdi, sdo, sdo_oe_n, conv, acq, span, highz, turbo, stat_en;
    int err_count = 0;
    int n_tests = 0;
    int cycles = 0;

    adc_serial_config_interface u_adc_serial_config_interface (
        .i_clk(clk), .i_rst(rst), .i_sck(sck), .i_convert_strobe(strobe), .i_sdi(sdi),
        .i_busy_select(busy_sel), .i_overvoltage(ovr), .i_sample_code(code),
        .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_converting(conv), .o_acquiring(acq),
        .o_span_compress(span), .o_high_z(highz), .o_turbo(turbo), .o_status_en(stat_en)
    );

    asci_host_model u_asci_host_model (
        .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n), .o_sck(sck), .o_strobe(strobe), .o_sdi(sdi)
    );

    // 25 MHz core clock
    always #20 clk = ~clk;

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    // Frame plus slack so the conversion started by the strobe rise runs out
    task automatic xfer(input logic [31:0] tx, input int n, output logic [31:0] rx);
        u_asci_host_model.frame(tx, n, rx);
        repeat (12) @(posedge clk);
        #1;
    endtask : xfer

    task automatic wr(input logic [7:0] d);
        logic [31:0] rx;
        xfer({16'h0000, 8'h14, d}, 16, rx);
    endtask : wr

    task automatic rd(output logic [7:0] d);
        logic [31:0] rx;
        xfer({16'h0000, 8'h54, 8'h00}, 16, rx);
        d = rx[7:0];
    endtask : rd

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_power_up();
        logic [7:0] got;
        repeat (6) @(posedge clk);
        #1;
        `CHK("sdo_oe_n in reset", 1'b0, sdo_oe_n)
        @(posedge clk) rst <= 1'b0;
        repeat (6) @(posedge clk);
        #1;
        `CHK("sdo_oe_n idle high", 1'b1, sdo_oe_n)
        `CHK("cfg pins at reset", 4'h0, {stat_en, span, highz, turbo})
        rd(got);
        `CHK("cfg reset value", 8'h01, got)
    endtask : t_power_up

    // Reserved bits and the flag must not take the written ones
    task automatic t_write_read();
        logic [7:0] vals [3] = '{8'hFF, 8'h00, 8'h0A};
        logic [7:0] got;
        foreach (vals[i])
        begin
            wr(vals[i]);
            `CHK("cfg pins", vals[i][4:1], {stat_en, span, highz, turbo})
            rd(got);
            `CHK("cfg readback", (vals[i] & 8'h1E) | 8'h01, got)
        end
    endtask : t_write_read

    // Wrong first bit, wrong pattern, short frame: all leave 0x0A alone
    task automatic t_bad_cmd();
        logic [7:0] cmds [3] = '{8'h94, 8'h15, 8'h34};
        logic [31:0] rx;
        foreach (cmds[i])
        begin
            xfer({16'h0000, cmds[i], 8'hF5}, 16, rx);
            `CHK("cfg after bad command", 4'h5, {stat_en, span, highz, turbo})
        end
        xfer({20'h00000, 8'h14, 4'hF}, 12, rx);
        `CHK("cfg after short write", 4'h5, {stat_en, span, highz, turbo})
    endtask : t_bad_cmd

    // Result, six status bits, then SDI passed through for the chain
    task automatic t_result();
        logic [31:0] tx = 32'h2D5AB3C5;
        logic [31:0] rx;
        @(posedge clk) code <= 16'hA5C3;
        busy_sel <= 1'b1;
        wr(8'h1C);
        xfer(tx, 30, rx);
        `CHK("result", 16'hA5C3, rx[28:13])
        `CHK("status", 6'h38, rx[12:7])
        `CHK("chain data", tx[7:1], rx[6:0])
        // Frame reopened mid-conversion: SDO stays released until the result is in
        @(posedge clk) code <= 16'h3C96;
        u_asci_host_model.early_open();
        repeat (3) @(posedge clk);
        #1;
        `CHK("busy early", 3'b110, {sdo_oe_n, conv, acq})
        repeat (3) @(posedge clk);
        #1;
        `CHK("busy late", 3'b111, {sdo_oe_n, conv, acq})
        repeat (4) @(posedge clk);
        #1;
        `CHK("busy over", 3'b001, {sdo_oe_n, conv, acq})
        xfer(32'hFFFFFFFF, 17, rx);
        `CHK("busy result", 16'h3C96, rx[15:0])
        @(posedge clk) busy_sel <= 1'b0;
    endtask : t_result

    // Flag stays low while clamp active, cleared by the first read after, reads high on the second
    task automatic t_overvoltage();
        logic [7:0] got;
        for (int i = 0; i < 4; i++)
        begin
            @(posedge clk) ovr <= (i < 2);
            repeat (5) @(posedge clk);
            rd(got);
            `CHK("overvoltage flag", i == 3, got[0])
        end
    endtask : t_overvoltage

    initial
    begin
        t_power_up();
        t_write_read();
        t_bad_cmd();
        t_result();
        t_overvoltage();
        give_verdict();
    end
endmodule : adc_serial_config_interface_bench
`default_nettype wire
